// ### ccf_charge_control_fsm.sv
`default_nettype none
module ccf_charge_control_fsm
  import ccf_pkg::*;
#(
  parameter logic [39:0] PRE_CYC = 40'(PRE_TMR_CYC),
  parameter logic [39:0] FAST_CYC = 40'(FAST_TMR_CYC),
  parameter logic [31:0] WDT_CYC = 32'(WDT_MAX_CYC),
  parameter logic [23:0] TERM_CYCLES = 24'(TERM_CYC)
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire ccf_sense_t sense_in,
  output var ccf_power_t power_out,
  output var logic int_o,
  output var logic int_oe,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output var logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output var logic s_axi_wready,
  output var logic [1:0] s_axi_bresp,
  output var logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output var logic s_axi_arready,
  output var logic [31:0] s_axi_rdata,
  output var logic [1:0] s_axi_rresp,
  output var logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    ccf_sense_t sync1;
    ccf_sense_t sync2;
    ccf_sense_t prev;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic wstb;
    logic [7:0] r_pwr;
    logic [7:0] r_ichg;
    logic [7:0] r_ipre;
    logic [7:0] r_vreg;
    logic [7:0] r_tmr;
    logic [7:0] r_misc;
    logic [7:0] flt;
    logic host;
    logic [31:0] wdt;
    ccf_phase_t phase;
    logic [39:0] tmr;
    logic deg_run;
    logic [23:0] deg;
    logic done;
    logic diode;
    logic chg_dis_d;
    logic hiz_d;
    logic [11:0] int_cnt;
    logic int_oe;
    logic int_lvl;
    ccf_power_t pwr;
  } ccf_state_t;

  localparam ccf_state_t ST_RST = '{r_pwr: PWR_DEF, r_ichg: ICHG_DEF, r_ipre: IPRE_DEF,
                                    r_vreg: VREG_DEF, r_tmr: TMR_DEF, r_misc: MISC_DEF,
                                    int_lvl: 1'b1, phase: PH_OFF, default: '0};

  function automatic logic [39:0] fast_lim(input logic [1:0] f, input logic [39:0] b);
    return b << f;
  endfunction

  function automatic logic [31:0] wdt_lim(input logic [1:0] f, input logic [31:0] m);
    return m >> (2'h3 - f);
  endfunction

  logic rst_meta_ff;
  logic rst_n_ff;
  ccf_state_t st_ff;
  ccf_state_t nxt_st;
  ccf_sense_t sn;
  logic chg_dis, hiz, term_en, ttc, safe_en, tsen, tsel;
  logic therm_flt, otp, kill, safe_flt, tmr_rst, start_ok, trig, auto_rech;
  logic aw_take, w_take, ar_take, wr_go, rd_flt, wdt_on, wdt_ev, in_rise, chg_on, ev;
  logic [5:0] widx;
  logic [5:0] ridx;
  logic [7:0] flt_live;
  logic [7:0] flt_set;

  // ****************************************
  // Reset release
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    sn = st_ff.sync2;
    nxt_st.sync1 = sense_in;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.prev = sn;
    wdt_ev = 1'b0;
    in_rise = sn.input_good & ~st_ff.prev.input_good;

    chg_dis = st_ff.r_pwr[PWR_CHG_DIS];
    hiz = st_ff.r_pwr[PWR_HIZ];
    term_en = st_ff.r_tmr[TMR_TERM_EN];
    ttc = st_ff.r_tmr[TMR_TTC];
    safe_en = st_ff.r_tmr[TMR_SAFE_EN];
    tsen = st_ff.r_misc[MISC_TSEN];
    tsel = st_ff.r_misc[MISC_TSEL];
    therm_flt = tsen & tsel & sn.ntc_out_window;
    otp = tsen & ~tsel & sn.ntc_below_hot;
    kill = sn.tj_shutdown | otp;

    // Watchdog only runs in host mode with input present
    wdt_on = st_ff.host & (st_ff.r_tmr[TMR_WDT_LSB+:2] != 2'h0);
    if (!wdt_on) begin
      nxt_st.wdt = '0;
    end else if (sn.input_good) begin
      if (st_ff.wdt >= wdt_lim(st_ff.r_tmr[TMR_WDT_LSB+:2], WDT_CYC) - 32'h0000_0001) begin
        wdt_ev = 1'b1;
        nxt_st.host = 1'b0;
        nxt_st.wdt = '0;
        nxt_st.r_pwr = PWR_DEF;
        nxt_st.r_ichg = ICHG_DEF;
        nxt_st.r_ipre = IPRE_DEF;
        nxt_st.r_vreg = VREG_DEF;
        nxt_st.r_tmr = TMR_DEF;
        nxt_st.r_misc = MISC_DEF;
      end else begin
        nxt_st.wdt = st_ff.wdt + 32'h0000_0001;
      end
    end

    // ****************************************
    // AXI4-Lite write
    // ****************************************
    aw_take = s_axi_awvalid & st_ff.awready;
    w_take = s_axi_wvalid & st_ff.wready;
    wr_go = st_ff.aw_have & st_ff.w_have & ~st_ff.bvalid;
    widx = st_ff.awaddr[7:2];
    if (aw_take) begin
      nxt_st.aw_have = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (w_take) begin
      nxt_st.w_have = 1'b1;
      nxt_st.wdata = s_axi_wdata[7:0];
      nxt_st.wstb = s_axi_wstrb[0];
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (wr_go) begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = RESP_OKAY;
      nxt_st.host = 1'b1;
      if (widx < IDX_PWR || widx > IDX_STAT || widx == 6'h07) begin
        nxt_st.bresp = RESP_SLVERR;
      end else if (st_ff.wstb) begin
        case (widx)
          IDX_PWR: begin
            // Kick bit is a strobe and is never stored
            nxt_st.r_pwr = st_ff.wdata & ~(8'h01 << PWR_KICK);
            if (st_ff.wdata[PWR_KICK]) begin
              nxt_st.wdt = '0;
            end
          end
          IDX_ICHG: nxt_st.r_ichg = st_ff.wdata & 8'h1F;
          IDX_IPRE: nxt_st.r_ipre = st_ff.wdata & 8'h03;
          IDX_VREG: nxt_st.r_vreg = st_ff.wdata & 8'hFD;
          IDX_TMR: nxt_st.r_tmr = st_ff.wdata & 8'h7F;
          IDX_MISC: nxt_st.r_misc = st_ff.wdata & 8'h0F;
          default: nxt_st.bresp = RESP_OKAY;
        endcase
      end
    end
    nxt_st.awready = ~nxt_st.aw_have & ~nxt_st.bvalid;
    nxt_st.wready = ~nxt_st.w_have & ~nxt_st.bvalid;

    // ****************************************
    // Charge cycle
    // ****************************************
    tmr_rst = (chg_dis ^ st_ff.chg_dis_d) | (hiz ^ st_ff.hiz_d) | in_rise;
    nxt_st.chg_dis_d = chg_dis;
    nxt_st.hiz_d = hiz;
    auto_rech = (st_ff.phase == PH_DONE) & sn.batt_below_rech & sn.input_good
                & term_en & ~ttc;
    trig = in_rise | (st_ff.chg_dis_d & ~chg_dis) | auto_rech;
    safe_flt = (st_ff.phase == PH_TIMEOUT) & ~tmr_rst;
    start_ok = sn.input_good & ~chg_dis & ~hiz & ~therm_flt & ~safe_flt
               & ~sn.batt_ovp & ~kill;
    if (!st_ff.done && (st_ff.phase == PH_PRE || st_ff.phase == PH_CC
                        || st_ff.phase == PH_CV)) begin
      nxt_st.tmr = st_ff.tmr + 40'h00_0000_0001;
    end
    case (st_ff.phase)
      PH_PRE: begin
        if (sn.batt_above_pre) begin
          nxt_st.phase = PH_CC;
          nxt_st.tmr = '0;
        end else if (safe_en && st_ff.tmr >= PRE_CYC - 40'h00_0000_0001) begin
          nxt_st.phase = PH_TIMEOUT;
        end
      end
      PH_CC: begin
        if (sn.batt_at_reg) begin
          nxt_st.phase = PH_CV;
        end else if (safe_en && st_ff.tmr >= fast_lim(st_ff.r_tmr[TMR_FAST_LSB+:2], FAST_CYC)
                     - 40'h00_0000_0001) begin
          nxt_st.phase = PH_TIMEOUT;
        end
      end
      PH_CV: begin
        if (!st_ff.done && safe_en && st_ff.tmr >= fast_lim(st_ff.r_tmr[TMR_FAST_LSB+:2],
            FAST_CYC) - 40'h00_0000_0001) begin
          nxt_st.phase = PH_TIMEOUT;
        end else if (!term_en || st_ff.done) begin
          nxt_st.deg_run = 1'b0;
        end else if (!st_ff.deg_run) begin
          nxt_st.deg_run = sn.ichg_at_term;
          nxt_st.deg = '0;
        end else if (!sn.ibatt_below_hys) begin
          nxt_st.deg_run = 1'b0;
        end else if (st_ff.deg >= TERM_CYCLES - 24'h00_0001) begin
          nxt_st.done = 1'b1;
          nxt_st.deg_run = 1'b0;
          if (!ttc) begin
            nxt_st.phase = PH_DONE;
          end
        end else begin
          nxt_st.deg = st_ff.deg + 24'h00_0001;
        end
      end
      PH_TIMEOUT: begin
        if (tmr_rst) begin
          nxt_st.phase = PH_OFF;
        end
      end
      PH_OFF, PH_DONE: nxt_st.phase = st_ff.phase;
      default: nxt_st.phase = PH_OFF;
    endcase
    if (trig && start_ok && (st_ff.phase == PH_OFF || st_ff.phase == PH_DONE
                             || st_ff.phase == PH_TIMEOUT)) begin
      nxt_st.phase = sn.batt_above_pre ? PH_CC : PH_PRE;
      nxt_st.tmr = '0;
      nxt_st.done = 1'b0;
      nxt_st.deg_run = 1'b0;
    end
    if (tmr_rst) begin
      nxt_st.tmr = '0;
    end
    // Loss of input or host disable ends the cycle; a timeout stays visible on loss of input, a host disable clears it
    if ((!sn.input_good || chg_dis || hiz) && st_ff.phase != PH_TIMEOUT) begin
      nxt_st.phase = PH_OFF;
      nxt_st.done = 1'b0;
      nxt_st.deg_run = 1'b0;
    end

    // Suspension is immediate and needs no restart once the cause clears
    chg_on = (st_ff.phase == PH_PRE || st_ff.phase == PH_CC || st_ff.phase == PH_CV)
             & ~sn.batt_ovp & ~therm_flt & ~kill & sn.input_good;
    if (kill) begin
      nxt_st.diode = 1'b0;
    end else if (sn.sys_below_batt) begin
      nxt_st.diode = 1'b1;
    end else if (sn.sys_above_batt) begin
      nxt_st.diode = 1'b0;
    end

    // ****************************************
    // Power path outputs
    // ****************************************
    nxt_st.pwr.input_to_system_switch = sn.input_good & ~hiz & ~kill;
    nxt_st.pwr.battery_switch = ~kill & (~sn.input_good | chg_on | nxt_st.diode);
    nxt_st.pwr.charge_enable = chg_on;
    nxt_st.pwr.precharge_mode = st_ff.phase == PH_PRE;
    nxt_st.pwr.cv_mode = st_ff.phase == PH_CV;
    nxt_st.pwr.reduce_current = sn.sys_at_min | sn.tj_at_reg;
    nxt_st.pwr.ideal_diode = nxt_st.diode;
    nxt_st.pwr.charge_complete = nxt_st.done;
    nxt_st.pwr.charge_current = st_ff.r_ichg[4:0];
    nxt_st.pwr.precharge_current = st_ff.r_ipre[1:0];
    nxt_st.pwr.full_charge_voltage = st_ff.r_vreg[VREG_LSB+:6];
    nxt_st.pwr.recharge_sel = st_ff.r_vreg[VREG_RECH];
    nxt_st.pwr.tj_limit = st_ff.r_misc[MISC_TJ_LSB+:2];

    // ****************************************
    // Faults
    // ****************************************
    ar_take = s_axi_arvalid & st_ff.arready;
    ridx = s_axi_araddr[7:2];
    rd_flt = ar_take & (ridx == IDX_FLT);
    flt_live = '0;
    flt_live[FLT_TSD] = sn.tj_shutdown;
    flt_live[FLT_OVP] = sn.batt_ovp;
    flt_live[FLT_TEMP] = otp | therm_flt;
    flt_set = flt_live;
    flt_set[FLT_WDT] = wdt_ev;
    flt_set[FLT_IN] = ~sn.input_good & st_ff.prev.input_good;
    flt_set[FLT_SAFE] = (nxt_st.phase == PH_TIMEOUT) & (st_ff.phase != PH_TIMEOUT);
    // A fault arriving with the read is kept
    nxt_st.flt = (rd_flt ? (st_ff.flt & flt_live) : st_ff.flt) | flt_set;
    nxt_st.flt[FLT_TEMP] = flt_live[FLT_TEMP];

    // ****************************************
    // AXI4-Lite read
    // ****************************************
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (ar_take) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = RESP_OKAY;
      nxt_st.rdata = '0;
      case (ridx)
        IDX_PWR: nxt_st.rdata[7:0] = st_ff.r_pwr;
        IDX_ICHG: nxt_st.rdata[7:0] = st_ff.r_ichg;
        IDX_IPRE: nxt_st.rdata[7:0] = st_ff.r_ipre;
        IDX_VREG: nxt_st.rdata[7:0] = st_ff.r_vreg;
        IDX_TMR: nxt_st.rdata[7:0] = st_ff.r_tmr;
        IDX_MISC: nxt_st.rdata[7:0] = st_ff.r_misc;
        IDX_FLT: nxt_st.rdata[7:0] = st_ff.flt;
        IDX_STAT: nxt_st.rdata[7:0] = {st_ff.host, st_ff.done, st_ff.diode, chg_on,
                                       1'b0, st_ff.phase};
        default: nxt_st.rresp = RESP_SLVERR;
      endcase
    end
    nxt_st.arready = ~nxt_st.rvalid;

    // ****************************************
    // Interrupt pulse
    // ****************************************
    ev = in_rise | (nxt_st.done & ~st_ff.done) | (nxt_st.phase != st_ff.phase)
         | (|(flt_set & ~st_ff.flt));
    if (ev) begin
      nxt_st.int_cnt = INT_CYC;
    end else if (st_ff.int_cnt != 12'h000) begin
      nxt_st.int_cnt = st_ff.int_cnt - 12'h001;
    end
    nxt_st.int_oe = nxt_st.int_cnt != 12'h000;
    nxt_st.int_lvl = ~nxt_st.int_oe;
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign power_out = st_ff.pwr;
  assign int_o = st_ff.int_lvl;
  assign int_oe = st_ff.int_oe;
  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready = st_ff.wready;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign s_axi_rvalid = st_ff.rvalid;
endmodule
`default_nettype wire

// ### ccf_pkg.sv
`default_nettype none
package ccf_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam longint unsigned PRE_TMR_S = 3600;
  localparam longint unsigned PRE_TMR_CYC = PRE_TMR_S * longint'(CLK_HZ);
  localparam longint unsigned FAST_TMR_S = 3600;
  localparam longint unsigned FAST_TMR_CYC = FAST_TMR_S * longint'(CLK_HZ);
  localparam longint unsigned WDT_MAX_S = 160;
  localparam longint unsigned WDT_MAX_CYC = WDT_MAX_S * longint'(CLK_HZ);
  localparam int unsigned TERM_DEGLITCH_NS = 2_500_000;
  localparam int unsigned TERM_CYC = (TERM_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INT_PULSE_NS = 256_000;
  localparam logic [11:0] INT_CYC = 12'(INT_PULSE_NS / CLK_PERIOD_NS);
  // ****************************************
  // Register indices, byte address is four times the index
  // ****************************************
  localparam logic [5:0] IDX_PWR = 6'h01;
  localparam logic [5:0] IDX_ICHG = 6'h02;
  localparam logic [5:0] IDX_IPRE = 6'h03;
  localparam logic [5:0] IDX_VREG = 6'h04;
  localparam logic [5:0] IDX_TMR = 6'h05;
  localparam logic [5:0] IDX_MISC = 6'h06;
  localparam logic [5:0] IDX_FLT = 6'h08;
  localparam logic [5:0] IDX_STAT = 6'h09;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int PWR_KICK = 6;
  localparam int PWR_CHG_DIS = 3;
  localparam int PWR_HIZ = 2;
  localparam int TMR_TERM_EN = 6;
  localparam int TMR_WDT_LSB = 4;
  localparam int TMR_SAFE_EN = 3;
  localparam int TMR_FAST_LSB = 1;
  localparam int TMR_TTC = 0;
  localparam int VREG_LSB = 2;
  localparam int VREG_RECH = 0;
  localparam int MISC_TSEN = 3;
  localparam int MISC_TSEL = 2;
  localparam int MISC_TJ_LSB = 0;
  localparam int FLT_WDT = 7;
  localparam int FLT_IN = 6;
  localparam int FLT_TSD = 5;
  localparam int FLT_SAFE = 4;
  localparam int FLT_OVP = 3;
  localparam int FLT_TEMP = 1;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] PWR_DEF = 8'h00;
  localparam logic [7:0] ICHG_DEF = 8'h08;
  localparam logic [7:0] IPRE_DEF = 8'h01;
  localparam logic [7:0] VREG_DEF = 8'hA0;
  localparam logic [7:0] TMR_DEF = 8'h78;
  localparam logic [7:0] MISC_DEF = 8'h0B;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {PH_OFF, PH_PRE, PH_CC, PH_CV, PH_DONE, PH_TIMEOUT} ccf_phase_t;
  typedef struct packed {
    logic input_good;
    logic batt_above_pre;
    logic batt_at_reg;
    logic batt_ovp;
    logic batt_below_rech;
    logic ichg_at_term;
    logic ibatt_below_hys;
    logic sys_at_min;
    logic sys_below_batt;
    logic sys_above_batt;
    logic tj_at_reg;
    logic tj_shutdown;
    logic ntc_below_hot;
    logic ntc_out_window;
  } ccf_sense_t;
  typedef struct packed {
    logic input_to_system_switch;
    logic battery_switch;
    logic charge_enable;
    logic precharge_mode;
    logic cv_mode;
    logic reduce_current;
    logic ideal_diode;
    logic charge_complete;
    logic [4:0] charge_current;
    logic [1:0] precharge_current;
    logic [5:0] full_charge_voltage;
    logic recharge_sel;
    logic [1:0] tj_limit;
  } ccf_power_t;
endpackage
`default_nettype wire

// ### ccf_charge_control_fsm_asserts.sv
`default_nettype none
module ccf_charge_control_fsm_asserts
  import ccf_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire ccf_sense_t sense_in,
  input wire ccf_power_t power_out,
  input wire logic int_o,
  input wire logic int_oe
);
  // ****************
  // Checks
  // ****************
  // Outputs lag the internal reset, so the ideal diode and reduce current checks wait until this settles
  logic [2:0] up_ff;
  logic up;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) up_ff <= 3'h0;
    else if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
  end
  assign up = (up_ff == 3'h7);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_int_pulse: assert property ($rose(int_oe) |-> int_oe[*8])
    else $error("interrupt pulse too short");
  a_int_drive: assert property (int_o ^ int_oe)
    else $error("interrupt pin level wrong");
  a_phase_excl: assert property (!(power_out.precharge_mode && power_out.cv_mode))
    else $error("pre-charge and cv together");
  a_cv_cause: assert property ($rose(power_out.cv_mode) |->
    $past(sense_in.batt_at_reg, 3) || $past(sense_in.batt_at_reg, 4))
    else $error("cv entered below full charge voltage");
  a_noin_nochg: assert property (!sense_in.input_good[*4] |-> !power_out.charge_enable)
    else $error("charging without input");
  a_ovp_stop: assert property (sense_in.batt_ovp[*4] |-> !power_out.charge_enable)
    else $error("charging during battery over-voltage");
  a_tsd_off: assert property (sense_in.tj_shutdown[*4] |->
    !power_out.input_to_system_switch && !power_out.battery_switch)
    else $error("switch on in thermal shutdown");
  // A shutdown, or a board over-temperature with TSEN set and TSEL clear, drops the diode path whatever the system level
  a_diode_on: assert property (
    (up && sense_in.sys_below_batt && !sense_in.tj_shutdown && !sense_in.ntc_below_hot)[*4]
    |-> power_out.ideal_diode)
    else $error("ideal diode not enabled");
  a_reduce_cur: assert property (
    (up && (sense_in.sys_at_min || sense_in.tj_at_reg))[*4] ##0 power_out.charge_enable
    |-> power_out.reduce_current)
    else $error("charge current not reduced");
endmodule
bind ccf_charge_control_fsm ccf_charge_control_fsm_asserts ccf_chk_inst (.clk(clk),
  .reset_n(reset_n), .sense_in(sense_in), .power_out(power_out), .int_o(int_o),
  .int_oe(int_oe));
`default_nettype wire

// ### ccf_batt_model.sv
`default_nettype none
module ccf_batt_model
  import ccf_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire ccf_power_t power_in,
  input wire logic [13:0] ovr,
  input wire logic hold,
  output var ccf_sense_t sense_out
);
  // ****************
  // Cell level and taper
  // ****************
  logic [6:0] lvl_ff;
  logic [4:0] tap_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lvl_ff <= 7'h0;
      tap_ff <= 5'h0;
    end else begin
      if (hold) lvl_ff <= 7'h0;
      else if (power_in.charge_enable && lvl_ff < 7'h64) lvl_ff <= lvl_ff + 7'h1;
      // System load drains the cell as soon as charging stops
      else if (!power_in.charge_enable && lvl_ff != 7'h0) lvl_ff <= lvl_ff - 7'h1;
      if (!power_in.cv_mode) tap_ff <= 5'h0;
      else if (tap_ff != 5'h1f) tap_ff <= tap_ff + 5'h1;
    end
  end
  always_comb begin
    sense_out = ccf_sense_t'(ovr);
    sense_out.batt_above_pre |= (lvl_ff >= 7'h28);
    sense_out.batt_at_reg |= (lvl_ff >= 7'h64);
    sense_out.batt_below_rech |= (lvl_ff < 7'h5a);
    sense_out.ichg_at_term |= (tap_ff >= 5'h14);
    sense_out.ibatt_below_hys |= (tap_ff >= 5'h14);
  end
endmodule
`default_nettype wire

// ### testbench.sv
`default_nettype none
module testbench
  import ccf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hold = 1'b0;
  logic [13:0] ovr = 14'h0;
  ccf_sense_t sense;
  ccf_power_t pwr;
  logic int_o, int_oe, awr, wrdy, bv, arr, rv;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h1;
  logic [1:0] bresp, rresp;
  logic [17:0] q[$];
  logic [17:0] e;
  logic [4:0] ichg;
  int n_errors = 0, n_compared = 0, cyc = 0, seed = 29748;
  logic [7:0] defs [1:6] = '{PWR_DEF, ICHG_DEF, IPRE_DEF, VREG_DEF, TMR_DEF, MISC_DEF};
  logic [3:0] fb [6] = '{4'ha, 4'h2, 4'h1, 4'h5, 4'h6, 4'h3};
  logic [7:0] fm [6] = '{8'h08, 8'h20, 8'h02, 8'h00, 8'h00, 8'h00};
  // Expected system switch, battery switch, ideal diode, reduce current per forced sense bit
  logic [3:0] fx [6] = '{4'h8, 4'h0, 4'h0, 4'he, 4'hf, 4'hf};
  always #50 clk = ~clk;
  ccf_charge_control_fsm #(.PRE_CYC(40'h0c8), .FAST_CYC(40'h12c), .WDT_CYC(32'h190),
    .TERM_CYCLES(24'h14)) ccf_charge_control_fsm_inst (.clk(clk), .reset_n(reset_n),
    .sense_in(sense), .power_out(pwr), .int_o(int_o), .int_oe(int_oe),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rready));
  ccf_batt_model ccf_batt_model_inst (.clk(clk), .reset_n(reset_n), .power_in(pwr),
    .ovr(ovr), .hold(hold), .sense_out(sense));
  // ****************
  // Checking and bus tasks
  // ****************
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [5:0] ix, input logic [7:0] d,
      input logic [1:0] r = RESP_OKAY, input logic [3:0] s = 4'h1);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    q.push_back({8'h00, r, 8'h00});
    @(posedge clk);
    awaddr <= {ix, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(a && w)) begin
      @(posedge clk);
      a = a || (awv && awr);
      w = w || (wv && wrdy);
      awv <= awv && !awr;
      wv <= wv && !wrdy;
    end
    bready <= 1'b1;
    do @(posedge clk); while (!bv);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] ix, input logic [7:0] m, input logic [7:0] x,
      input logic [1:0] r = RESP_OKAY);
    q.push_back({m, r, x & m});
    @(posedge clk);
    araddr <= {ix, 2'b00};
    arv <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rready <= 1'b0;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return pwr.precharge_mode;
      1: return pwr.cv_mode;
      2: return pwr.charge_complete;
      default: return pwr.charge_enable;
    endcase
  endfunction
  task automatic ws(input int s, input logic v);
    int i;
    for (i = 0; i < 2000 && pick(s) !== v; i++) @(posedge clk);
    chk("wait", {33'h0, pick(s)}, {33'h0, v});
  endtask
  always @(posedge clk) begin
    if ((rv && rready) || (bv && bready)) begin
      e = q.pop_front();
      if (rv) chk("rdata", {rdata[31:8], rdata[7:0] & e[17:10], rresp},
        {24'h0, e[7:0], e[9:8]});
      else chk("bresp", {32'h0, bresp}, {32'h0, e[9:8]});
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    int i;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk("cfg", {27'h0, pwr.battery_switch, pwr.input_to_system_switch, pwr.tj_limit,
      pwr.precharge_current, pwr.recharge_sel}, {27'h0, 2'b10, MISC_DEF[1:0], IPRE_DEF[1:0],
      VREG_DEF[VREG_RECH]});
    for (i = 1; i <= 6; i++) rd(6'(i), 8'hff, defs[i]);
    rd(6'h00, 8'h00, 8'h00, RESP_SLVERR);
    rd(IDX_STAT, 8'h80, 8'h00);
    wr(6'h07, 8'h55, RESP_SLVERR);
    rd(IDX_STAT, 8'h80, 8'h80);
    wr(IDX_IPRE, 8'h02, RESP_OKAY, 4'h0);
    rd(IDX_IPRE, 8'hff, IPRE_DEF);
    ichg = 5'($random(seed));
    wr(IDX_ICHG, {3'h0, ichg});
    wr(IDX_TMR, 8'h48);
    ovr[13] <= 1'b1;
    ws(0, 1'b1);
    chk("int", {32'h0, int_oe, int_o}, 34'h2);
    rd(IDX_STAT, 8'h07, 8'h01);
    ws(0, 1'b0);
    rd(IDX_STAT, 8'h07, 8'h02);
    chk("ichg", {29'h0, pwr.charge_current}, {29'h0, ichg});
    ws(1, 1'b1);
    rd(IDX_STAT, 8'h07, 8'h03);
    chk("vreg", {28'h0, pwr.full_charge_voltage}, {28'h0, VREG_DEF[7:2]});
    ws(2, 1'b1);
    rd(IDX_STAT, 8'h47, 8'h44);
    chk("cut", {33'h0, pwr.charge_enable}, 34'h0);
    ws(3, 1'b1);
    rd(IDX_STAT, 8'h10, 8'h10);
    for (i = 0; i < 6; i++) begin
      ovr[fb[i]] <= 1'b1;
      repeat (8) @(posedge clk);
      chk("path", {30'h0, pwr.input_to_system_switch, pwr.battery_switch, pwr.ideal_diode,
        pwr.reduce_current}, {30'h0, fx[i]});
      rd(IDX_FLT, fm[i], fm[i]);
      ovr[fb[i]] <= 1'b0;
      repeat (8) @(posedge clk);
      rd(IDX_FLT, 8'h00, 8'h00);
      rd(IDX_FLT, fm[i], 8'h00);
    end
    wr(IDX_TMR, 8'h58);
    repeat (60) @(posedge clk);
    wr(IDX_PWR, 8'h40);
    repeat (60) @(posedge clk);
    rd(IDX_STAT, 8'h80, 8'h80);
    repeat (150) @(posedge clk);
    rd(IDX_STAT, 8'h80, 8'h00);
    rd(IDX_TMR, 8'hff, TMR_DEF);
    hold <= 1'b1;
    ovr[13] <= 1'b0;
    repeat (8) @(posedge clk);
    ovr[13] <= 1'b1;
    ws(0, 1'b1);
    ws(0, 1'b0);
    rd(IDX_STAT, 8'h07, 8'h05);
    rd(IDX_FLT, 8'h10, 8'h10);
    hold <= 1'b0;
    wr(IDX_PWR, 8'h08);
    wr(IDX_PWR, 8'h00);
    ws(0, 1'b1);
    // Thermistor mode: an out-of-window cell only pauses charging, the system path stays up
    wr(IDX_MISC, 8'h0F);
    ovr <= ovr | 14'h0011;
    repeat (8) @(posedge clk);
    chk("therm", {31'h0, pwr.charge_enable, pwr.ideal_diode, pwr.input_to_system_switch},
      34'h1);
    rd(IDX_FLT, 8'h02, 8'h02);
    ovr[0] <= 1'b0;
    ws(3, 1'b1);
    give_verdict();
  end
endmodule
`default_nettype wire
